// file: rtl/sbs_pkg.sv
/*
  Shared constants for the servo brake sequencer: register map, reset
  values, limits, speed figures and the millisecond time base.
  Assumes a 100 MHz core clock and a word-wide AHB-Lite register bus.
*/
`default_nettype none
package sbs_pkg;
  // Clock rate and the millisecond tick derived from it
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Fixed speed boundary between static and rotating, in RPM
  localparam logic [15:0] STATIC_RPM = 16'h0014;
  // Fixed energized hold after brake drop in rotating sequence, ms
  localparam logic [15:0] ROT_HOLD_MS = 16'h0032;
  // Register byte offsets
  localparam logic [7:0] ADR_THRESH = 8'h00;
  localparam logic [7:0] ADR_DELAY = 8'h04;
  localparam logic [7:0] ADR_STATIC = 8'h08;
  localparam logic [7:0] ADR_GUARD = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  // Reset values
  localparam logic [15:0] RST_THRESH = 16'h001e;
  localparam logic [15:0] RST_DELAY = 16'h01f4;
  localparam logic [15:0] RST_STATIC = 16'h0096;
  localparam logic [15:0] RST_GUARD = 16'h00fa;
  // Limits
  localparam logic [15:0] MAX_THRESH = 16'h0bb8;
  localparam logic [15:0] MIN_DELAY = 16'h0001;
  localparam logic [15:0] MAX_DELAY = 16'h03e8;
  localparam logic [15:0] MAX_GUARD = 16'h01f4;
  // Status field positions
  localparam int unsigned ST_BRAKE = 0;
  localparam int unsigned ST_ENERGY = 1;
  localparam int unsigned ST_GUARD = 2;
  localparam int unsigned ST_STATE = 4;
  // Fault classes
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_C1 = 2'h1;
  localparam logic [1:0] FLT_C2 = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    SBS_OFF, SBS_RUN, SBS_ROT_WAIT, SBS_HOLD, SBS_DONE
  } sbs_state_t;
endpackage : sbs_pkg
`default_nettype wire

// file: rtl/sbs_ms_tick.sv
/*
  Millisecond tick divider: a one-cycle enable every TICK_CYC clocks.
  Assumes one core clock and an asynchronous active-high reset.
*/
`default_nettype none
module sbs_ms_tick
  import sbs_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic tick
);
  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  // Divider count
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // Wrap at the last count and pulse once
  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt = tick_nxt ? '0 : cnt_r + W'(1);
  end

  // Register only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : sbs_ms_tick
`default_nettype wire

// file: rtl/sbs_top.sv
/*
  Servo brake sequencer: decides brake-release output and motor energize
  from servo-enable, measured speed and fault class; settings on AHB-Lite.
  Assumes inputs synchronous to core_clk, speed as signed RPM, and a
  motion loop elsewhere that performs the zero-speed stop on request.
*/
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
module sbs_top
  import sbs_pkg::*;
#(
  // Clocks per millisecond tick; shorten only for quick runs
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic servo_enable,
  input wire logic signed [15:0] motor_speed,
  input wire logic [1:0] fault_class,
  output logic brake_release_out,
  output logic motor_energize,
  output logic zero_speed_stop,
  output logic command_ready
);
  // Millisecond enable
  logic tick;
  sbs_ms_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Clamp a written value into a range
  function automatic logic [15:0] clamp16(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      clamp16 = lo;
    end else if (v > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v;
    end
  endfunction : clamp16

  // Bus address-phase capture
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wadr_r, wadr_nxt;
  // Settings
  logic [15:0] thresh_r, thresh_nxt;
  logic [15:0] delay_r, delay_nxt;
  logic [15:0] static_r, static_nxt;
  logic [15:0] guard_r, guard_nxt;
  // Read data register
  logic [31:0] hrdata_r, hrdata_nxt;
  // Status word built from block state
  logic [31:0] status_w;

  // Valid transfer in this cycle's address phase
  logic acc;
  assign acc = hsel && hready && htrans[1];

  // Next-value logic for the bus slave and settings
  always_comb begin
    wr_pend_nxt = acc && hwrite;
    wadr_nxt = acc ? haddr[7:0] : wadr_r;
    thresh_nxt = thresh_r;
    delay_nxt = delay_r;
    static_nxt = static_r;
    guard_nxt = guard_r;
    hrdata_nxt = hrdata_r;
    if (wr_pend_r) begin
      // Writes apply at once, even mid-sequence
      case (wadr_r)
        ADR_THRESH: thresh_nxt = clamp16(hwdata[15:0], '0, MAX_THRESH);
        ADR_DELAY: delay_nxt = clamp16(hwdata[15:0], MIN_DELAY, MAX_DELAY);
        ADR_STATIC: static_nxt = clamp16(hwdata[15:0], MIN_DELAY, MAX_DELAY);
        ADR_GUARD: guard_nxt = clamp16(hwdata[15:0], '0, MAX_GUARD);
        default: ;
      endcase
    end
    if (acc && !hwrite) begin
      // Read data staged for the zero-wait data phase
      case (haddr[7:0])
        ADR_THRESH: hrdata_nxt = {16'h0000, thresh_r};
        ADR_DELAY: hrdata_nxt = {16'h0000, delay_r};
        ADR_STATIC: hrdata_nxt = {16'h0000, static_r};
        ADR_GUARD: hrdata_nxt = {16'h0000, guard_r};
        ADR_STATUS: hrdata_nxt = status_w;
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus and setting registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wadr_r <= 8'h00;
      thresh_r <= RST_THRESH;
      delay_r <= RST_DELAY;
      static_r <= RST_STATIC;
      guard_r <= RST_GUARD;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wadr_r <= wadr_nxt;
      thresh_r <= thresh_nxt;
      delay_r <= delay_nxt;
      static_r <= static_nxt;
      guard_r <= guard_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Never waits, always OKAY
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Absolute speed, saturating the single negative corner
  logic [15:0] abs_speed;
  always_comb begin
    if (motor_speed[15]) begin
      abs_speed = (motor_speed == 16'sh8000) ? 16'hffff
                                              : 16'(-motor_speed);
    end else begin
      abs_speed = 16'(motor_speed);
    end
  end

  // Sequencer state
  sbs_state_t state_r, state_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic en_d_r, en_d_nxt;
  logic brake_r, brake_nxt;
  logic energy_r, energy_nxt;
  logic zss_r, zss_nxt;
  logic ready_r, ready_nxt;
  logic [15:0] gcnt_r, gcnt_nxt;

  logic fault_any, en_fall, slow;
  assign fault_any = (fault_class != FLT_NONE);
  assign en_fall = en_d_r && !servo_enable;
  assign slow = abs_speed < STATIC_RPM;

  // Sequencer next-state logic
  always_comb begin
    state_nxt = state_r;
    ms_nxt = ms_r;
    hold_nxt = hold_r;
    en_d_nxt = servo_enable;
    brake_nxt = brake_r;
    energy_nxt = energy_r;
    zss_nxt = zss_r;
    ready_nxt = ready_r;
    gcnt_nxt = gcnt_r;
    case (state_r)
      SBS_OFF: begin
        if (servo_enable && !fault_any) begin
          state_nxt = SBS_RUN;
          brake_nxt = 1'b1;
          energy_nxt = 1'b1;
          gcnt_nxt = '0;
          ready_nxt = 1'b0;
        end
      end
      SBS_RUN: begin
        if (!ready_r && tick) begin
          if (gcnt_r >= guard_r) begin
            ready_nxt = 1'b1;
          end else begin
            gcnt_nxt = gcnt_r + 16'h0001;
          end
        end
        if (fault_class == FLT_C2) begin
          zss_nxt = 1'b1;
          ready_nxt = 1'b0;
          state_nxt = SBS_ROT_WAIT;
          ms_nxt = '0;
        end else if (fault_class == FLT_C1 || en_fall) begin
          ready_nxt = 1'b0;
          ms_nxt = '0;
          if (fault_class == FLT_C1 || !slow) begin
            state_nxt = SBS_ROT_WAIT;
            zss_nxt = 1'b1;
          end else begin
            brake_nxt = 1'b0;
            hold_nxt = static_r;
            state_nxt = SBS_HOLD;
          end
        end
      end
      SBS_ROT_WAIT: begin
        zss_nxt = 1'b1;
        if (fault_class == FLT_C2) begin
          // class 2: below 20 RPM drop now
          if (slow) begin
            brake_nxt = 1'b0;
            hold_nxt = static_r;
            state_nxt = SBS_HOLD;
          end
        end else if (tick) begin
          ms_nxt = ms_r + 16'h0001;
          if (abs_speed <= thresh_r || ms_nxt >= delay_r) begin
            brake_nxt = 1'b0;
            hold_nxt = ROT_HOLD_MS;
            state_nxt = SBS_HOLD;
          end
        end
      end
      SBS_HOLD: begin
        // Count energized hold, then drop the motor
        if (tick) begin
          if (hold_r <= 16'h0001) begin
            energy_nxt = 1'b0;
            zss_nxt = 1'b0;
            state_nxt = SBS_DONE;
          end else begin
            hold_nxt = hold_r - 16'h0001;
          end
        end
      end
      SBS_DONE: begin
        // Rearm only after enable seen low and fault cleared
        if (!servo_enable && !fault_any) begin
          state_nxt = SBS_OFF;
        end
      end
      default: state_nxt = SBS_OFF;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= SBS_OFF;
      ms_r <= '0;
      hold_r <= '0;
      en_d_r <= 1'b0;
      brake_r <= 1'b0;
      energy_r <= 1'b0;
      zss_r <= 1'b0;
      ready_r <= 1'b0;
      gcnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      ms_r <= ms_nxt;
      hold_r <= hold_nxt;
      en_d_r <= en_d_nxt;
      brake_r <= brake_nxt;
      energy_r <= energy_nxt;
      zss_r <= zss_nxt;
      ready_r <= ready_nxt;
      gcnt_r <= gcnt_nxt;
    end
  end

  // Status view of live state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_BRAKE] = brake_r;
    status_w[ST_ENERGY] = energy_r;
    status_w[ST_GUARD] = ready_r;
    status_w[ST_STATE +: 3] = state_r;
  end

  assign brake_release_out = brake_r;
  assign motor_energize = energy_r;
  assign zero_speed_stop = zss_r;
  assign command_ready = ready_r;
endmodule : sbs_top
`default_nettype wire

// file: verification/sbs_top_properties.sv
/*
  Checker for sbs_top: brake and energize sequencing properties.
  Assumes it sees only top ports; bound into every sbs_top.
*/
`default_nettype none
module sbs_top_checker
  import sbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic servo_enable,
  input wire logic signed [15:0] motor_speed,
  input wire logic [1:0] fault_class,
  input wire logic brake_release_out,
  input wire logic motor_energize,
  input wire logic zero_speed_stop,
  input wire logic command_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Speed magnitude, sign ignored
  logic [15:0] spd_abs;
  // Below the static boundary
  logic slow;
  assign spd_abs = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
  assign slow = spd_abs < STATIC_RPM;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property (disable iff (1'h0)
    sys_rst |-> !brake_release_out && !motor_energize && !command_ready)
    else $error("outputs active in reset");
  a_enable_release: assert property ($rose(servo_enable) &&
    fault_class == FLT_NONE && $past(fault_class) == FLT_NONE &&
    !brake_release_out && !motor_energize
    |=> brake_release_out && motor_energize)
    else $error("enable did not release brake");
  a_brake_energy: assert property (brake_release_out |->
    motor_energize) else $error("brake released while de-energized");
  a_hold_energy: assert property ($fell(brake_release_out) |->
    motor_energize [*8]) else $error("energize lost at brake drop");
  a_static_drop: assert property ($fell(servo_enable) &&
    brake_release_out && slow && fault_class == FLT_NONE
    |=> !brake_release_out) else $error("static brake drop late");
  a_rot_keep: assert property ($fell(servo_enable) &&
    brake_release_out && !slow && fault_class == FLT_NONE
    |=> motor_energize [*8]) else $error("rotating stop lost energy");
  a_c2_stop: assert property (fault_class == FLT_C2 &&
    brake_release_out |-> ##[1:2] zero_speed_stop)
    else $error("no zero speed stop on class 2");
  a_c2_drop: assert property ((fault_class == FLT_C2 &&
    slow) [*3] |-> !brake_release_out) else $error("class 2 drop late");
  a_ready_brake: assert property ($rose(command_ready) |->
    brake_release_out) else $error("ready without release");
  cover property ($fell(brake_release_out) && !slow);
  cover property ($rose(zero_speed_stop));
  cover property ($fell(motor_energize));
endmodule : sbs_top_checker
bind sbs_top sbs_top_checker u_sbs_top_checker (.core_clk, .sys_rst,
  .servo_enable, .motor_speed, .fault_class, .brake_release_out,
  .motor_energize, .zero_speed_stop, .command_ready);
`default_nettype wire

// file: verification/sbs_motor_model.sv
/*
  Motor and motion controller model: speed falls 1 RPM a cycle.
  Assumes the bench loads a start speed and may ask it to coast.
*/
`default_nettype none
module sbs_motor_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic signed [15:0] start_speed,
  input wire logic coast,
  input wire logic servo_enable,
  input wire logic zero_speed_stop,
  input wire logic brake_release_out,
  input wire logic command_ready,
  output logic signed [15:0] motor_speed,
  output logic ref_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Speed state and next
  logic signed [15:0] spd_r, spd_nxt;
  // Slowing while stopping or once enable is off
  logic decel;
  assign decel = !coast && spd_r > 0 && (zero_speed_stop || !servo_enable);
  // Reference issue state
  logic ref_r, ref_nxt;
  // Coasting stands for a load that will not slow
  always_comb begin
    spd_nxt = spd_r;
    if (load) begin
      spd_nxt = start_speed;
    end else if (decel) begin
      spd_nxt = spd_r - 16'sh1;
    end
    ref_nxt = brake_release_out && command_ready;
  end
  // State registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spd_r <= 16'sh0;
      ref_r <= 1'h0;
    end else begin
      spd_r <= spd_nxt;
      ref_r <= ref_nxt;
    end
  end
  assign motor_speed = spd_r;
  assign ref_valid = ref_r;
endmodule : sbs_motor_model
`default_nettype wire

// file: verification/servo_brake_sequencer_test.sv
/*
  Bench for sbs_top: registers over AHB-Lite, then stop sequences.
  Runs the design with a 10-cycle tick, so a ms wait is 10 clocks.
*/
`default_nettype none
module servo_brake_sequencer_test
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] wd, ex;} sbs_row_t;
  logic core_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic servo_enable = 1'h0, load = 1'h0, coast = 1'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, fault_class = '0;
  logic [2:0] hsize = 3'h2;
  logic signed [15:0] start_speed = '0, motor_speed;
  logic hreadyout, hresp, brake_release_out, motor_energize;
  logic zero_speed_stop, command_ready, ref_valid;
  logic [3:0] mon;
  // Highest speed allowed at the brake drop of a fault stop
  logic signed [15:0] lim_spd;
  int errors = 0, compares = 0;
  logic [15:0] rv [4] = '{RST_THRESH, RST_DELAY, RST_STATIC, RST_GUARD};
  // Clamping and unmapped cases
  sbs_row_t rows [9] = '{'{8'h00, 32'hbb9, 32'hbb8},
    '{8'h00, 32'h32, 32'h32}, '{8'h04, 32'h0, 32'h1},
    '{8'h04, 32'h7d0, 32'h3e8}, '{8'h04, 32'h1, 32'h1},
    '{8'h08, 32'h1, 32'h1}, '{8'h0c, 32'h258, 32'h1f4},
    '{8'h0c, 32'h0, 32'h0}, '{8'h14, 32'h55, 32'h0}};
  assign mon = {hreadyout, command_ready, motor_energize, brake_release_out};
  // Short millisecond tick keeps every wait far below the run limit
  sbs_top #(.TICK_DIV(10)) u_sbs_top (.core_clk, .sys_rst, .haddr,
    .htrans, .hwrite,
    .hsize, .hsel, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .servo_enable, .motor_speed, .fault_class, .brake_release_out,
    .motor_energize, .zero_speed_stop, .command_ready);
  sbs_motor_model u_sbs_motor_model (.core_clk, .sys_rst, .load,
    .start_speed, .coast, .servo_enable, .zero_speed_stop,
    .brake_release_out, .command_ready, .motor_speed, .ref_valid);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] seen, ex);
    compares++;
    if (seen !== ex) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // Bounded wait on one monitored flag
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[s] !== v) begin
      @(posedge core_clk);
      n++;
      if (n > lim) begin
        errors++;
        finish_test();
      end
    end
  endtask : wait_for
  // One single-word transfer, read data into rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'h1;
    @(posedge core_clk);
    wait_for(3, 1'h1, 50);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    wait_for(3, 1'h1, 50);
    rd = hrdata;
  endtask : bus
  task automatic do_rst(input logic [15:0] dly);
    sys_rst <= 1'h1;
    servo_enable <= 1'h0;
    fault_class <= FLT_NONE;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    bus(8'h00, 1'h1, 32'h32);
    bus(8'h04, 1'h1, {16'h0, dly});
    bus(8'h08, 1'h1, 32'h2);
    // Quiet after a mid-run reset, bus ready and OKAY
    chk("idle", {mon, hresp, zero_speed_stop, ref_valid}, 7'h40);
  endtask : do_rst
  task automatic go(input logic signed [15:0] s);
    @(posedge core_clk);
    load <= 1'h1;
    start_speed <= s;
    servo_enable <= 1'h1;
    @(posedge core_clk);
    load <= 1'h0;
    @(negedge core_clk);
    chk("release", {brake_release_out, motor_energize}, 2'h3);
  endtask : go
  task automatic off_and_wait(input int lim);
    @(posedge core_clk);
    servo_enable <= 1'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("held", brake_release_out, 1'h1);
    wait_for(0, 1'h0, lim);
  endtask : off_and_wait
  initial begin
    // First reset leaves the settings at their reset values
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    chk("idle", {brake_release_out, motor_energize}, 2'h0);
    for (int i = 0; i < 4; i++) begin
      bus(8'(4 * i), 1'h0, '0);
      chk("reset value", rd, {16'h0, rv[i]});
    end
    foreach (rows[i]) begin
      bus(rows[i].a, 1'h1, rows[i].wd);
      bus(rows[i].a, 1'h0, '0);
      chk("readback", rd, rows[i].ex);
    end
    // Static stop, guard zero; two ms hold outlasts a short first tick
    bus(8'h08, 1'h1, 32'h2);
    go(16'sha);
    wait_for(2, 1'h1, 100);
    bus(8'h10, 1'h0, '0);
    chk("status", rd[2:0], 3'h7);
    @(posedge core_clk);
    servo_enable <= 1'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("static", {brake_release_out, motor_energize}, 2'h1);
    wait_for(1, 1'h0, 500);
    // Rotating stop ended by the threshold
    do_rst(16'h3e8);
    go(16'sh64);
    off_and_wait(2000);
    chk("thresh", {motor_speed <= 16'sh32, motor_energize}, 2'h3);
    // Rotating stop ended by the delay
    do_rst(16'h1);
    coast <= 1'h1;
    go(16'sh64);
    off_and_wait(2000);
    chk("delay", {motor_speed == 16'sh64, motor_energize}, 2'h3);
    coast <= 1'h0;
    // Class 1 then class 2 faults
    for (int f = 1; f < 3; f++) begin
      do_rst(16'h3e8);
      go(16'sh64);
      @(posedge core_clk);
      fault_class <= 2'(f);
      // Class 1 drops at the threshold, class 2 below the static bound
      lim_spd = (f == 1) ? 16'sh32 : 16'sh13;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("stop", zero_speed_stop, 1'h1);
      wait_for(0, 1'h0, 2000);
      chk("fault", {motor_speed <= lim_spd, motor_energize}, 2'h3);
    end
    finish_test();
  end
endmodule : servo_brake_sequencer_test
`default_nettype wire
